// ### rtl/lighting_master_process_image.sv
// Purpose: process image and telegram cycle control of a lighting-bus master
// Assumes: image bytes and transmitter run on clk; supply fault is a raw pin
// Notes: line coding lives in the transmitter behind txRequest/txResult
//   one flip queues behind a running cycle
//   register mode is echoed, never served
//
// Function
// - four bytes each of input and output image
// - bytes at offset 0, words at 1 or 2
// - command bit 15 picks short or group address
// - command bits 14..9 carry the target address
// - command bit 8 picks level or command code
// - reply bit 8 set only for valid answer
// - dimming mode sends bits 7..0 to all
// - dimming mode reply word carries nothing
// - control bit 7 low means process-data mode
// - control bit 1 repeats extension commands 224-255
// - each toggle change outside register mode sends one telegram; a later queued flip replaces an earlier one
// - telegrams start at least 25 ms apart
// - telegram cycle lasts 25 to 43.34 ms
// - status toggle flips when cycle completes
// - status bit 0 change acknowledges sent telegram
// - collision flags clear at next status flip
`timescale 1ns/10ps
`include "lighting_params.svh"

module lighting_master_process_image #(
    // least cycle time, rounded up to whole clocks
    parameter int MIN_CYCLE_CLKS =
        (`SPACING_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    // longest cycle time, rounded down to whole clocks
    parameter int MAX_CYCLE_CLKS = (`CYCLE_MAX_US * 1000) / `CLK_PERIOD_NS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // process image toward the fieldbus coupler
    input wire logic alignWords,
    input wire logic [3:0][7:0] outImage,
    output logic [3:0][7:0] inImage,
    // operating mode and supply monitor
    input wire logic dimMode,
    input wire logic supplyFault,
    // line transmitter
    output lighting_pkg::tx_request_t txRequest,
    output logic txStart,
    input wire lighting_pkg::tx_result_t txResult
);

    // ==========================================================
    // declarations
    lighting_pkg::state_t state;       // registered state
    lighting_pkg::state_t next_state;  // next value of state
    logic [7:0] controlByte;           // decoded control byte
    logic [15:0] commandWord;          // decoded command word
    logic [7:0] statusByte;            // status byte as presented
    logic toggleFlip;                  // controller changed its toggle
    logic launchNow;                   // a new cycle starts this clock
    logic finishNow;                   // the running cycle completes
    logic [`ELAPSED_WIDTH-1:0] minLast; // last clock before least time
    logic [`ELAPSED_WIDTH-1:0] maxLast; // last clock before timeout

    assign minLast = `ELAPSED_WIDTH'(MIN_CYCLE_CLKS - 1);
    assign maxLast = `ELAPSED_WIDTH'(MAX_CYCLE_CLKS - 1);

    // true for a command code that the repeat option covers
    // shared by the launch logic and the repeat property
    function automatic logic isExtension(input logic [15:0] cmd, input logic dim);
        isExtension = !dim && cmd[`CMD_SEL] && (cmd[7:0] >= `EXT_FIRST);
    endfunction : isExtension

    // ==========================================================
    // image mapping
    // layout moves only the word; byte 0 is fixed
    process_image_map imageMap (
        .alignWords(alignWords),
        .outImage(outImage),
        .statusByte(statusByte),
        .replyWord(state.reply),
        .controlByte(controlByte),
        .commandWord(commandWord),
        .inImage(inImage)
    );

    // ==========================================================
    // outputs straight from state flops
    // address, group and select bits pass untouched to the transmitter
    assign txRequest = state.active;
    assign txStart = state.txStart;
    // bits 5..3 are reserved and read zero
    assign statusByte = {state.regEcho, state.errLevel, 3'h0, state.bwdFlag,
                         state.fwdFlag, state.ackToggle};

    // ==========================================================
    // edge and cycle decisions
    // a queued flip launches at the finish edge
    // a flip while register mode is on is consumed, not queued
    assign toggleFlip = state.primed && (controlByte[`CB_TOGGLE] != state.lastToggle)
                        && !controlByte[`CB_REGMODE];
    assign finishNow = ((state.phase == lighting_pkg::HOLD) && (state.elapsed >= minLast))
                    || ((state.phase == lighting_pkg::SEND) && (state.elapsed >= maxLast));
    assign launchNow = (state.phase == lighting_pkg::IDLE && (toggleFlip || state.pending))
                    || (finishNow && state.pending);

    // ==========================================================
    // next state
    always_comb begin
        next_state = state;
        // launch pulse lasts one clock
        next_state.txStart = 1'b0;
        // first clock after reset only takes the reference
        next_state.primed = 1'b1;
        next_state.lastToggle = controlByte[`CB_TOGGLE];
        // echoed one clock late
        next_state.regEcho = controlByte[`CB_REGMODE];
        // supply fault: change taken once the last two stages agree
        next_state.errSync = {state.errSync[1:0], supplyFault};
        // stage one may be settling; only stage two reads it
        if (state.errSync[1] == state.errSync[2]) begin
            next_state.errLevel = state.errSync[2];
        end
        // flip captured now; one cycle may queue behind the running one
        if (toggleFlip) begin
            next_state.pending = 1'b1;
            next_state.pendingCmd = commandWord;
            next_state.pendingRepeat = controlByte[`CB_REPEAT];
            next_state.pendingDim = dimMode;
        end
        // elapsed time of the running cycle, saturating
        // saturating keeps a stuck transmitter from wrapping
        if (state.phase != lighting_pkg::IDLE && state.elapsed != '1) begin
            next_state.elapsed = state.elapsed + `ELAPSED_WIDTH'(1);
        end
        // collisions only matter in addressed mode
        if (state.phase != lighting_pkg::IDLE && !state.active.dimMode) begin
            next_state.fwdSeen = state.fwdSeen | txResult.fwdCollision;
            next_state.bwdSeen = state.bwdSeen | txResult.bwdCollision;
        end
        unique case (state.phase)
            lighting_pkg::IDLE: begin
                // launch handled below
            end
            lighting_pkg::SEND: begin
                if (txResult.done) begin
                    // pad out to the least cycle time
                    next_state.phase = lighting_pkg::HOLD;
                    next_state.replySeen = txResult.replyValid;
                    next_state.replyData = txResult.reply;
                end
            end
            lighting_pkg::HOLD: begin
                // wait out the least cycle time
            end
        endcase
        if (finishNow) begin
            // acknowledge: flip toggle, publish flags and reply
            next_state.phase = lighting_pkg::IDLE;
            next_state.ackToggle = !state.ackToggle;
            // flags reflect only this cycle, so old ones clear here
            next_state.fwdFlag = state.fwdSeen | (!state.active.dimMode & txResult.fwdCollision);
            next_state.bwdFlag = state.bwdSeen | (!state.active.dimMode & txResult.bwdCollision);
            // timeout or dimming cycles report no answer
            if (state.active.dimMode) begin
                next_state.reply = `REPLY_RESET;
            end else if (state.replySeen && state.phase == lighting_pkg::HOLD) begin
                next_state.reply = {7'h00, 1'b1, state.replyData};
            end else begin
                next_state.reply = `REPLY_RESET;
            end
        end
        if (launchNow) begin
            // a queued flip keeps its own command; a fresh one uses the word now
            next_state.phase = lighting_pkg::SEND;
            next_state.txStart = 1'b1;
            // cycle bookkeeping restarts here
            next_state.elapsed = '0;
            next_state.fwdSeen = 1'b0;
            next_state.bwdSeen = 1'b0;
            next_state.replySeen = 1'b0;
            next_state.pending = toggleFlip && state.pending && !finishNow &&
                                 state.phase != lighting_pkg::IDLE;
            if (state.pending) begin
                // queued values were frozen at their own flip
                next_state.active.frame = state.pendingCmd;
                next_state.active.dimMode = state.pendingDim;
                next_state.active.repeatTwice = state.pendingRepeat &&
                    isExtension(state.pendingCmd, state.pendingDim);
            end else begin
                next_state.active.frame = commandWord;
                next_state.active.dimMode = dimMode;
                next_state.active.repeatTwice = controlByte[`CB_REPEAT] &&
                    isExtension(commandWord, dimMode);
            end
            if (toggleFlip && state.pending) begin
                // the fresh flip queues behind the one launched now
                next_state.pending = 1'b1;
                next_state.pendingCmd = commandWord;
                next_state.pendingRepeat = controlByte[`CB_REPEAT];
                next_state.pendingDim = dimMode;
            end
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= '0;
            // named for clarity; both are zero
            state.phase <= lighting_pkg::IDLE;
            state.reply <= `REPLY_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // checks
    // helpers for the spacing property only
    logic [`ELAPSED_WIDTH-1:0] gapCount; // clocks since the last launch
    logic started;                       // at least one launch seen
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gapCount <= '0;
            started <= 1'b0;
        end else if (txStart) begin
            gapCount <= `ELAPSED_WIDTH'(1);
            started <= 1'b1;
        end else if (gapCount != '1) begin
            gapCount <= gapCount + `ELAPSED_WIDTH'(1);
        end
    end

    // a flip met with nothing queued
    sequence idleFlip;
        state.phase == lighting_pkg::IDLE && !state.pending && toggleFlip;
    endsequence

    // the acknowledge bit changed this clock
    sequence ackFlip;
        statusByte[`SB_TOGGLE] != $past(statusByte[`SB_TOGGLE]);
    endsequence

    // an idle flip launches next clock
    flip_launches_a: assert property (@(posedge clk) disable iff (rst)
        idleFlip |=> txStart)
        else $error("toggle flip did not launch a telegram");

    // frame equals the word at the flip
    sample_at_flip_a: assert property (@(posedge clk) disable iff (rst)
        idleFlip |=> txRequest.frame == $past(commandWord))
        else $error("command word not sampled at the flip");

    // every launch traces to a flip
    no_stray_launch_a: assert property (@(posedge clk) disable iff (rst)
        txStart |-> $past(toggleFlip) || $past(state.pending))
        else $error("telegram launched without a toggle flip");

    // register mode launches nothing unless a flip is already queued
    regmode_blocks_a: assert property (@(posedge clk) disable iff (rst)
        controlByte[`CB_REGMODE] && !state.pending |=> !txStart)
        else $error("telegram launched in register mode");

    // launches keep the least spacing
    launch_spacing_a: assert property (@(posedge clk) disable iff (rst)
        txStart && started |-> gapCount >= `ELAPSED_WIDTH'(MIN_CYCLE_CLKS))
        else $error("telegrams closer than the least spacing");

    // each cycle ends inside its window
    cycle_length_a: assert property (@(posedge clk) disable iff (rst)
        finishNow |-> state.elapsed >= minLast && state.elapsed <= maxLast)
        else $error("telegram cycle outside its time window");

    // every finish flips the acknowledge
    ack_follows_finish_a: assert property (@(posedge clk) disable iff (rst)
        finishNow |=> ackFlip)
        else $error("status toggle did not flip at cycle end");

    // reserved bits zero, no valid flag after dimming
    reply_reserved_a: assert property (@(posedge clk) disable iff (rst)
        finishNow |=> state.reply[15:9] == 7'h00
            && !(state.reply[`RSP_OK] && $past(state.active.dimMode)))
        else $error("reply word reserved bits or valid flag wrong");

    // dimming leaves the reply empty
    dim_reply_empty_a: assert property (@(posedge clk) disable iff (rst)
        finishNow && state.active.dimMode |=> state.reply == `REPLY_RESET)
        else $error("dimming mode reply word not empty");

    // repeat only for extension codes
    repeat_option_a: assert property (@(posedge clk) disable iff (rst)
        txStart && !isExtension(txRequest.frame, txRequest.dimMode) |-> !txRequest.repeatTwice)
        else $error("repeat requested for a non-extension command");

    // a clean cycle clears both flags
    collision_clear_a: assert property (@(posedge clk) disable iff (rst)
        finishNow && !state.fwdSeen && !state.bwdSeen && !txResult.fwdCollision
        && !txResult.bwdCollision |=> !statusByte[`SB_FWD_COLL] && !statusByte[`SB_BWD_COLL])
        else $error("collision flag survived a clean cycle");

endmodule : lighting_master_process_image

// ### rtl/lighting_params.svh
// Purpose: constants for the lighting-bus master process image
// Assumes: included by bare name from every design file that needs it
// Notes: offsets are byte offsets inside the four-byte image
`ifndef LIGHTING_PARAMS_SVH
`define LIGHTING_PARAMS_SVH

// ==========================================================
// image layout
`define IMAGE_BYTES 3
`define CTRL_OFFSET 0
`define DATA_OFFSET_PACKED 1
`define DATA_OFFSET_ALIGNED 2

// ==========================================================
// control byte fields
`define CB_TOGGLE 0
`define CB_REPEAT 1
`define CB_REGMODE 7

// ==========================================================
// status byte fields
`define SB_TOGGLE 0
`define SB_FWD_COLL 1
`define SB_BWD_COLL 2
`define SB_ERROR 6
`define SB_REGMODE 7
`define STATUS_RESET 8'h00

// ==========================================================
// command and reply word fields
`define CMD_GROUP 15
`define CMD_ADDR_HI 14
`define CMD_ADDR_LO 9
`define CMD_SEL 8
`define RSP_OK 8
`define EXT_FIRST 8'he0
`define REPLY_RESET 16'h0000

// ==========================================================
// timing
`define CLK_PERIOD_NS 40
`define SPACING_MS 25
`define CYCLE_MAX_US 43340
`define ELAPSED_WIDTH 21

`endif

// ### rtl/lighting_pkg.sv
// Purpose: types shared by the process image block and its line transmitter
// Assumes: constants come from lighting_params.svh
// Notes: nothing here is synthesised on its own
package lighting_pkg;

    // ==========================================================
    // telegram cycle phase
    typedef enum logic [1:0] {
        IDLE = 2'b00,  // waiting for a control toggle flip
        SEND = 2'b01,  // transmitter busy with the telegram
        HOLD = 2'b10   // telegram done, padding to the least cycle time
    } phase_t;

    // request handed to the line transmitter
    typedef struct packed {
        logic [15:0] frame;   // command word as sampled at the flip
        logic dimMode;        // broadcast dimming instead of addressed mode
        logic repeatTwice;    // send an extension command a second time
    } tx_request_t;

    // result returned by the line transmitter
    typedef struct packed {
        logic done;           // one-cycle pulse: telegram finished
        logic replyValid;     // a device answered in the backward frame
        logic [7:0] reply;    // backward frame contents
        logic fwdCollision;   // collision while sending, level
        logic bwdCollision;   // collision while receiving, level
    } tx_result_t;

    // complete state of the process image block
    typedef struct packed {
        phase_t phase;
        logic primed;                // first toggle sample taken after reset
        logic lastToggle;            // control toggle as last seen
        logic pending;               // a flip waits for the running cycle
        logic [15:0] pendingCmd;
        logic pendingRepeat;
        logic pendingDim;
        tx_request_t active;         // request being served
        logic txStart;               // one-cycle launch pulse
        logic [20:0] elapsed;        // cycles since launch
        logic fwdSeen;
        logic bwdSeen;
        logic replySeen;
        logic [7:0] replyData;
        logic ackToggle;
        logic fwdFlag;
        logic bwdFlag;
        logic regEcho;
        logic [15:0] reply;
        logic [2:0] errSync;
        logic errLevel;
    } state_t;

endpackage : lighting_pkg

// ### rtl/process_image_map.sv
// Purpose: place control, status and data words into the byte image
// Assumes: the word sits low byte first at its offset
// Notes: pure wiring, no state
`timescale 1ns/10ps
`include "lighting_params.svh"

module process_image_map (
    // layout choice
    input wire logic alignWords,
    // output image written by the controller
    input wire logic [3:0][7:0] outImage,
    // block side values
    input wire logic [7:0] statusByte,
    input wire logic [15:0] replyWord,
    // decoded controller values
    output logic [7:0] controlByte,
    output logic [15:0] commandWord,
    // input image read by the controller
    output logic [3:0][7:0] inImage
);

    // ==========================================================
    // decode and encode
    // the unused byte reads zero so a packed image never shows stale data
    always_comb begin
        controlByte = outImage[`CTRL_OFFSET];
        inImage = '0;
        inImage[`CTRL_OFFSET] = statusByte;
        if (alignWords) begin
            commandWord = {outImage[`DATA_OFFSET_ALIGNED + 1], outImage[`DATA_OFFSET_ALIGNED]};
            inImage[`DATA_OFFSET_ALIGNED] = replyWord[7:0];
            inImage[`DATA_OFFSET_ALIGNED + 1] = replyWord[15:8];
        end else begin
            commandWord = {outImage[`DATA_OFFSET_PACKED + 1], outImage[`DATA_OFFSET_PACKED]};
            inImage[`DATA_OFFSET_PACKED] = replyWord[7:0];
            inImage[`DATA_OFFSET_PACKED + 1] = replyWord[15:8];
        end
    end

endmodule : process_image_map

// ### testbench/lighting_master_process_image_tb.sv
// Purpose: self-checking bench for the lighting-bus master process image
// Assumes: cycle limits shortened to 20 and 40 clocks
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/10ps
`include "lighting_params.svh"

module lighting_master_process_image_tb;
    // ==========================================================
    // signals
    localparam int MIN = 20; // shortened least cycle
    localparam int MAX = 40; // shortened longest cycle
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic alignWords = 1'b0;
    logic [3:0][7:0] outImage = '0;
    logic [3:0][7:0] inImage;
    logic dimMode = 1'b0;
    logic supplyFault = 1'b0;
    lighting_pkg::tx_request_t txRequest;
    logic txStart;
    lighting_pkg::tx_result_t txResult;
    logic [7:0] doneDelay = 8'h05;
    logic ansValid = 1'b0;
    logic [7:0] ansByte = 8'h00;
    logic fwdCol = 1'b0;
    logic bwdCol = 1'b0;
    logic [7:0] ctrlByte = 8'h00; // control byte as last written
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;
    int starts = 0; // launches seen
    int k;
    int t1;
    logic sb;

    lighting_master_process_image #(.MIN_CYCLE_CLKS(MIN), .MAX_CYCLE_CLKS(MAX)) dut (
        .clk(clk), .rst(rst), .alignWords(alignWords), .outImage(outImage),
        .inImage(inImage), .dimMode(dimMode), .supplyFault(supplyFault),
        .txRequest(txRequest), .txStart(txStart), .txResult(txResult));

    tx_line_model line (
        .clk(clk), .rst(rst), .txStart(txStart), .txRequest(txRequest),
        .doneDelay(doneDelay), .ansValid(ansValid), .ansByte(ansByte),
        .fwdCol(fwdCol), .bwdCol(bwdCol), .txResult(txResult));

    // ==========================================================
    // clock, launch count and hang limit
    initial begin
        forever #20 clk = ~clk;
    end

    // the limit is far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (txStart === 1'b1) starts++;
        if (cycles == 5000) begin
            fail_count++;
            complete_run();
        end
    end

    // ==========================================================
    // access tasks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // word goes low byte first; the unused byte carries junk to be ignored
    task automatic put(input logic [15:0] cmd);
        @(posedge clk);
        #1;
        outImage[0] = ctrlByte;
        outImage[3:1] = alignWords ? {cmd, 8'ha5} : {8'h3c, cmd};
    endtask : put

    function automatic logic [15:0] reply();
        return alignWords ? {inImage[3], inImage[2]} : {inImage[2], inImage[1]};
    endfunction : reply

    task automatic waitStart(output int n);
        n = 0;
        while (txStart !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : waitStart

    // one full telegram cycle: flip, launch, acknowledge
    task automatic send(input logic [15:0] cmd, input logic rep, input logic [15:0] expReply,
            input int expLen);
        int n;
        logic old;
        logic expRep;
        old = inImage[0][`SB_TOGGLE];
        expRep = !dimMode && cmd[`CMD_SEL] && (cmd[7:0] >= `EXT_FIRST) && rep;
        ctrlByte = {ctrlByte[7:2], rep, ~ctrlByte[0]};
        put(cmd);
        waitStart(n);
        check("launch delay", 16'(n), 16'h0001);
        check("request frame", txRequest.frame, cmd);
        check("request mode", {txRequest.dimMode, txRequest.repeatTwice}, {dimMode, expRep});
        n = 0;
        while (inImage[0][`SB_TOGGLE] === old && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("cycle length", 16'(n), 16'(expLen));
        check("reply word", reply(), expReply);
    endtask : send

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    // ==========================================================
    // test sequence
    initial begin
        repeat (20) @(posedge clk);
        #1;
        check("image in reset", {inImage[1:0]}, 16'h0000);
        check("image high in reset", {inImage[3:2]}, 16'h0000);
        rst = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        // group address, command code, valid answer
        ansValid = 1'b1;
        ansByte = 8'h5a;
        send(16'h8d23, 1'b0, 16'h015a, MIN);
        check("spare byte packed", 16'(inImage[3]), 16'h0000);
        $display("test addressed done");
        // extension code with repeat and no answer, then level e0 with answer, aligned words
        alignWords = 1'b1;
        ansValid = 1'b0;
        send(16'h01e5, 1'b1, 16'h0000, MIN);
        ansValid = 1'b1;
        send(16'h7ee0, 1'b0, 16'h015a, MIN);
        check("spare byte aligned", 16'(inImage[1]), 16'h0000);
        alignWords = 1'b0;
        $display("test extension done");
        // dimming mode carries a level and returns nothing
        dimMode = 1'b1;
        ansValid = 1'b1;
        send(16'h01e8, 1'b1, 16'h0000, MIN);
        dimMode = 1'b0;
        $display("test dimming done");
        // collisions show at one acknowledge and clear at the next
        fwdCol = 1'b1;
        bwdCol = 1'b1;
        send(16'h0a10, 1'b0, 16'h015a, MIN);
        check("collision flags", 16'(inImage[0][2:1]), 16'h0003);
        fwdCol = 1'b0;
        bwdCol = 1'b0;
        send(16'h0a10, 1'b0, 16'h015a, MIN);
        check("flags cleared", 16'(inImage[0][2:1]), 16'h0000);
        $display("test collision done");
        // no answer before the longest cycle ends
        doneDelay = 8'hc8;
        send(16'h0b01, 1'b0, 16'h0000, MAX);
        doneDelay = 8'h05;
        $display("test timeout done");
        // second flip while busy waits for the running cycle
        sb = inImage[0][`SB_TOGGLE];
        ctrlByte[0] = ~ctrlByte[0];
        put(16'h0110);
        waitStart(k);
        t1 = int'($time);
        ctrlByte[0] = ~ctrlByte[0];
        put(16'h0220);
        put(16'h0bad);
        waitStart(k);
        check("first acknowledge", 16'(inImage[0][`SB_TOGGLE]), 16'(!sb));
        check("launch spacing", 16'((int'($time) - t1) / 40 >= MIN), 16'h0001);
        check("queued frame", txRequest.frame, 16'h0220);
        repeat (MAX + 5) @(posedge clk);
        #1;
        check("two acknowledges", 16'(inImage[0][`SB_TOGGLE]), 16'(sb));
        $display("test spacing done");
        // no launch without a flip, nor in register mode
        k = starts;
        put(16'h1234);
        repeat (MAX) @(posedge clk);
        #1;
        check("launch without flip", 16'(starts - k), 16'h0000);
        ctrlByte = {1'b1, ctrlByte[6:1], ~ctrlByte[0]};
        put(16'h1234);
        repeat (MAX) @(posedge clk);
        #1;
        check("register mode launch", 16'(starts - k), 16'h0000);
        check("mode echo", 16'(inImage[0][`SB_REGMODE]), 16'h0001);
        ctrlByte[7] = 1'b0;
        put(16'h1234);
        repeat (4) @(posedge clk);
        #1;
        check("mode echo off", 16'(inImage[0][`SB_REGMODE]), 16'h0000);
        $display("test no launch done");
        // supply fault reaches the error bit through the synchroniser
        supplyFault = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        check("supply error", 16'(inImage[0][`SB_ERROR]), 16'h0001);
        supplyFault = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        check("supply clear", 16'(inImage[0][`SB_ERROR]), 16'h0000);
        $display("test supply done");
        complete_run();
    end
endmodule : lighting_master_process_image_tb

// ### testbench/tx_line_model.sv
// Purpose: behavioural line transmitter facing the process image block
// Assumes: one launch at a time; the bench shapes each answer through ports
// Notes: reply lines outside the done pulse show the inverse, never stale data
`timescale 1ns/10ps

module tx_line_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // launch from the block
    input wire logic txStart,
    input wire lighting_pkg::tx_request_t txRequest,
    // answer shaping set by the bench
    input wire logic [7:0] doneDelay,
    input wire logic ansValid,
    input wire logic [7:0] ansByte,
    input wire logic fwdCol,
    input wire logic bwdCol,
    // result back to the block
    output lighting_pkg::tx_result_t txResult
);
    // ==========================================================
    // telegram timing
    logic [7:0] count; // cycles left before done
    logic busy; // a telegram is on the line
    logic donePulse; // one-cycle completion

    // a delay above the block's longest cycle forces its timeout path
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= 8'h00;
            busy <= 1'b0;
            donePulse <= 1'b0;
        end else begin
            donePulse <= 1'b0;
            if (txStart) begin
                busy <= 1'b1;
                count <= txRequest.repeatTwice ? {doneDelay[6:0], 1'b0} : doneDelay;
            end else if (busy && count == 8'h00) begin
                busy <= 1'b0;
                donePulse <= 1'b1;
            end else if (busy) begin
                count <= count - 8'h01;
            end
        end
    end

    // reply only meaningful with done; collisions only while busy
    assign txResult = '{done: donePulse,
                        replyValid: donePulse ? ansValid : ~ansValid,
                        reply: donePulse ? ansByte : ~ansByte,
                        fwdCollision: busy & fwdCol,
                        bwdCollision: busy & bwdCol};
endmodule : tx_line_model
